// ---- address_breakpoint_unit_defines.svh ----
/*
 Constants of the address breakpoint unit: register offsets, field
 positions, reset values, vectors and interrupt bits.
 Assumes inclusion by bare name from the package and the unit module.
*/
// Summary of operation
// - address match with enable raises breakpoint request
// - break forces software interrupt opcode and vector
// - writing one to active bit breaks too
// - opcode-address break precedes that instruction
// - operand-address break follows that instruction
// - software break taken before next instruction
// - match sets active bit; software clears it
// - enable bit 7, read/write, zero disables
// - compare all 16 bits, gated by enable
// - reset clears both address bytes
// - reset clears active and enable bits
// - unchanged address gives no repeated break
// - return from interrupt ends break state
// - timer halted while break in progress
// - watchdog off in break under test voltage
// - flag clearing in break needs clear-enable
// - low-power modes keep enable, block address-match breaks
`ifndef ADDRESS_BREAKPOINT_UNIT_DEFINES_SVH
`define ADDRESS_BREAKPOINT_UNIT_DEFINES_SVH

`define ABU_ADDR_W        8
`define ABU_OFS_STATCTL   8'h00
`define ABU_OFS_ADDRHI    8'h04
`define ABU_OFS_ADDRLO    8'h08
`define ABU_OFS_IRQSTAT   8'h0C
`define ABU_OFS_IRQMASK   8'h10
`define ABU_OFS_FLAGCTL   8'h14

`define ABU_BIT_ENABLE    7
`define ABU_BIT_ACTIVE    6
`define ABU_BIT_FCE       0
`define ABU_BYTE_MSB      7
`define ABU_LANE_LOW      0

`define ABU_IRQ_W         3
`define ABU_IRQ_MATCH     0
`define ABU_IRQ_SOFT      1
`define ABU_IRQ_EXIT      2

`define ABU_RST_BYTE      8'h00
`define ABU_RST_WORD      32'h0000_0000
`define ABU_RST_IRQ       3'h0
`define ABU_VEC_USER      16'hFFFC
`define ABU_VEC_MONITOR   16'hFEFC

`endif

// ---- address_breakpoint_unit_pkg.sv ----
/*
 Types of the address breakpoint unit: break sequencing states and the
 packed record that holds all of the unit's state.
 Assumes the defines header is on the include path.
*/
`default_nettype none
`include "address_breakpoint_unit_defines.svh"

package address_breakpoint_unit_pkg;

	typedef enum logic [1:0]
	{
		BRK_IDLE,
		BRK_PEND,
		BRK_ACTIVE
	} brk_state_t;

	typedef struct packed
	{
		logic                   ack;
		logic [31:0]            rdData;
		logic                   breakEnable;
		logic                   breakActive;
		logic [7:0]             addrHigh;
		logic [7:0]             addrLow;
		logic                   matchBlock;
		brk_state_t             seq;
		logic                   request;
		logic                   swiForce;
		logic [15:0]            vector;
		logic [`ABU_IRQ_W-1:0]  irqStatus;
		logic [`ABU_IRQ_W-1:0]  irqMask;
		logic                   flagClearEn;
		logic                   tstMeta;
		logic                   tstSync;
		logic                   irq;
	} abu_regs_t;

endpackage : address_breakpoint_unit_pkg
`default_nettype wire

// ---- address_breakpoint_unit.sv ----
/*
 Address breakpoint unit: compares the core address bus with a
 programmed break address, sequences the break towards the core and
 system integration logic, and exposes its registers on classic
 Wishbone with a masked interrupt.
 Assumes the core marks valid addresses, opcode fetches, instruction
 boundaries and return-from-interrupt, all on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "address_breakpoint_unit_defines.svh"

module address_breakpoint_unit
(
	input  wire logic                  ref_clk,          // bus clock
	input  wire logic                  reset,            // async, high
	input  wire logic                  wb_cyc_i,         // bus cycle
	input  wire logic                  wb_stb_i,         // strobe
	input  wire logic                  wb_we_i,          // write
	input  wire logic [`ABU_ADDR_W-1:0] wb_adr_i,        // byte address
	input  wire logic [3:0]            wb_sel_i,         // byte lanes
	input  wire logic [31:0]           wb_dat_i,         // write data
	output logic [31:0]                wb_dat_o,         // read data
	output logic                       wb_ack_o,         // acknowledge
	input  wire logic [15:0]           cpuAddr,          // address bus
	input  wire logic                  cpuAddrValid,     // cpu address
	input  wire logic                  opcodeFetch,      // opcode cycle
	input  wire logic                  instrBoundary,    // next instr
	input  wire logic                  returnFromInterrupt, // rti done
	input  wire logic                  lowPowerMode,     // wait/stop
	input  wire logic                  monitorMode,      // monitor mode
	input  wire logic                  testHighVoltage,  // pin, async
	output logic                       breakpointRequest, // pulse
	output logic                       swiForce,         // load opcode
	output logic [15:0]                breakVector,      // vector addr
	output logic                       breakInProgress,  // break state
	output logic                       timerHalt,        // stop timer
	output logic                       watchdogDisable,  // stop wdog
	output logic                       flagClearAllowed, // status clr
	output logic                       irq               // interrupt
);

	address_breakpoint_unit_pkg::abu_regs_t state_ff;
	address_breakpoint_unit_pkg::abu_regs_t nxt_state;

	logic                  busReq;
	logic                  wrTake;
	logic                  wrLane;
	logic [15:0]           breakAddr;
	logic                  addrHit;
	logic                  swBreak;
	logic                  opcodeBreak;
	logic                  operandBreak;
	logic                  breakTaken;
	logic [`ABU_IRQ_W-1:0] irqEvents;
	logic [`ABU_IRQ_W-1:0] irqClear;

	assign busReq    = wb_cyc_i & wb_stb_i;
	// a write lands on the edge that samples ack high
	assign wrTake    = busReq & wb_we_i & state_ff.ack;
	assign wrLane    = wb_sel_i[`ABU_LANE_LOW];
	// live register contents, so a fresh address compares at once
	assign breakAddr = {state_ff.addrHigh, state_ff.addrLow};

	// full 16-bit compare gated by enable; static bus in low power
	assign addrHit = state_ff.breakEnable
		& cpuAddrValid
		& ~lowPowerMode
		& ~state_ff.matchBlock
		& (cpuAddr == breakAddr);

	assign swBreak = wrTake & wrLane
		& (wb_adr_i == `ABU_OFS_STATCTL)
		& wb_dat_i[`ABU_BIT_ACTIVE];

	assign opcodeBreak  = addrHit & opcodeFetch;
	assign operandBreak = addrHit & ~opcodeFetch;

	always_comb
	begin
		breakTaken = 1'b0;
		case (state_ff.seq)
			address_breakpoint_unit_pkg::BRK_IDLE:
				breakTaken = opcodeBreak;
			address_breakpoint_unit_pkg::BRK_PEND:
				breakTaken = instrBoundary;
			default:
				breakTaken = 1'b0;
		endcase
	end

	assign irqEvents = {
		(state_ff.seq == address_breakpoint_unit_pkg::BRK_ACTIVE)
			& returnFromInterrupt,
		swBreak,
		addrHit & (state_ff.seq != address_breakpoint_unit_pkg::BRK_ACTIVE)
	};

	assign irqClear = (wrTake & wrLane & (wb_adr_i == `ABU_OFS_IRQSTAT))
		? wb_dat_i[`ABU_IRQ_W-1:0] : `ABU_RST_IRQ;

	always_comb
	begin
		nxt_state = state_ff;

		// bus slave: ack one cycle after the request, then drop
		nxt_state.ack = busReq & ~state_ff.ack;
		if (busReq & ~state_ff.ack & ~wb_we_i)
		begin
			nxt_state.rdData = `ABU_RST_WORD;
			if (wb_adr_i == `ABU_OFS_STATCTL)
			begin
				nxt_state.rdData[`ABU_BIT_ENABLE] = state_ff.breakEnable;
				nxt_state.rdData[`ABU_BIT_ACTIVE] = state_ff.breakActive;
			end
			else if (wb_adr_i == `ABU_OFS_ADDRHI)
			begin
				nxt_state.rdData[`ABU_BYTE_MSB:0] = state_ff.addrHigh;
			end
			else if (wb_adr_i == `ABU_OFS_ADDRLO)
			begin
				nxt_state.rdData[`ABU_BYTE_MSB:0] = state_ff.addrLow;
			end
			else if (wb_adr_i == `ABU_OFS_IRQSTAT)
			begin
				nxt_state.rdData[`ABU_IRQ_W-1:0] = state_ff.irqStatus;
			end
			else if (wb_adr_i == `ABU_OFS_IRQMASK)
			begin
				nxt_state.rdData[`ABU_IRQ_W-1:0] = state_ff.irqMask;
			end
			else if (wb_adr_i == `ABU_OFS_FLAGCTL)
			begin
				nxt_state.rdData[`ABU_BIT_FCE] = state_ff.flagClearEn;
			end
			else
			begin
				nxt_state.rdData = `ABU_RST_WORD;
			end
		end

		// register writes; unmapped addresses are acked and dropped
		if (wrTake & wrLane)
		begin
			if (wb_adr_i == `ABU_OFS_STATCTL)
			begin
				nxt_state.breakEnable = wb_dat_i[`ABU_BIT_ENABLE];
				nxt_state.breakActive = wb_dat_i[`ABU_BIT_ACTIVE];
			end
			else if (wb_adr_i == `ABU_OFS_ADDRHI)
			begin
				nxt_state.addrHigh   = wb_dat_i[`ABU_BYTE_MSB:0];
				nxt_state.matchBlock = 1'b0;
			end
			else if (wb_adr_i == `ABU_OFS_ADDRLO)
			begin
				nxt_state.addrLow    = wb_dat_i[`ABU_BYTE_MSB:0];
				nxt_state.matchBlock = 1'b0;
			end
			else if (wb_adr_i == `ABU_OFS_IRQMASK)
			begin
				nxt_state.irqMask = wb_dat_i[`ABU_IRQ_W-1:0];
			end
			else if (wb_adr_i == `ABU_OFS_FLAGCTL)
			begin
				nxt_state.flagClearEn = wb_dat_i[`ABU_BIT_FCE];
			end
		end

		// a hardware match sets the active bit over a software clear
		if (addrHit)
		begin
			nxt_state.breakActive = 1'b1;
			nxt_state.matchBlock  = 1'b1;
		end

		// break sequencing toward the core
		nxt_state.request  = breakTaken;
		nxt_state.swiForce = breakTaken;
		if (breakTaken)
		begin
			nxt_state.vector = monitorMode
				? `ABU_VEC_MONITOR : `ABU_VEC_USER;
		end

		case (state_ff.seq)
			address_breakpoint_unit_pkg::BRK_IDLE:
			begin
				if (opcodeBreak)
				begin
					nxt_state.seq = address_breakpoint_unit_pkg::BRK_ACTIVE;
				end
				else if (operandBreak | swBreak)
				begin
					nxt_state.seq = address_breakpoint_unit_pkg::BRK_PEND;
				end
			end
			address_breakpoint_unit_pkg::BRK_PEND:
			begin
				if (instrBoundary)
				begin
					nxt_state.seq = address_breakpoint_unit_pkg::BRK_ACTIVE;
				end
			end
			address_breakpoint_unit_pkg::BRK_ACTIVE:
			begin
				if (returnFromInterrupt)
				begin
					nxt_state.seq = address_breakpoint_unit_pkg::BRK_IDLE;
				end
			end
			default:
			begin
				nxt_state.seq = address_breakpoint_unit_pkg::BRK_IDLE;
			end
		endcase

		// test voltage pin passes two flops before use
		nxt_state.tstMeta = testHighVoltage;
		nxt_state.tstSync = state_ff.tstMeta;

		// sticky events: set wins over write-one-to-clear
		nxt_state.irqStatus = (state_ff.irqStatus & ~irqClear) | irqEvents;
		nxt_state.irq = |(nxt_state.irqStatus & state_ff.irqMask);
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			state_ff.ack         <= 1'b0;
			state_ff.rdData      <= `ABU_RST_WORD;
			state_ff.breakEnable <= 1'b0;
			state_ff.breakActive <= 1'b0;
			state_ff.addrHigh    <= `ABU_RST_BYTE;
			state_ff.addrLow     <= `ABU_RST_BYTE;
			state_ff.matchBlock  <= 1'b0;
			state_ff.seq         <= address_breakpoint_unit_pkg::BRK_IDLE;
			state_ff.request     <= 1'b0;
			state_ff.swiForce    <= 1'b0;
			state_ff.vector      <= `ABU_VEC_USER;
			state_ff.irqStatus   <= `ABU_RST_IRQ;
			state_ff.irqMask     <= `ABU_RST_IRQ;
			state_ff.flagClearEn <= 1'b0;
			state_ff.tstMeta     <= 1'b0;
			state_ff.tstSync     <= 1'b0;
			state_ff.irq         <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign wb_ack_o          = state_ff.ack;
	assign wb_dat_o          = state_ff.rdData;
	assign breakpointRequest = state_ff.request;
	assign swiForce          = state_ff.swiForce;
	assign breakVector       = state_ff.vector;
	assign breakInProgress   = (state_ff.seq
		== address_breakpoint_unit_pkg::BRK_ACTIVE);
	assign timerHalt         = breakInProgress;
	assign watchdogDisable   = breakInProgress & state_ff.tstSync;
	assign flagClearAllowed  = ~breakInProgress
		| state_ff.flagClearEn;
	assign irq               = state_ff.irq;

endmodule : address_breakpoint_unit
`default_nettype wire

// ---- address_breakpoint_unit_checker.sv ----
/* Port assertions of the break unit.
 Sees only the unit's ports; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module abu_checker
(
	input wire logic	ref_clk,	// clock
	input wire logic	reset,	// reset
	input wire logic	monitorMode,	// mode
	input wire logic	testHighVoltage,	// pin
	input wire logic	returnFromInterrupt,	// rti
	input wire logic	breakpointRequest,	// take
	input wire logic	swiForce,	// opcode
	input wire logic [15:0]	breakVector,	// vector
	input wire logic	breakInProgress,	// break
	input wire logic	timerHalt,	// timer
	input wire logic	watchdogDisable,	// wdog
	input wire logic	flagClearAllowed	// clear ok
);
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	swi_pair_a: assert property (swiForce == breakpointRequest)
		else $error("swi force apart from take");
	vec_sel_a: assert property (breakpointRequest |->
		breakVector == ($past(monitorMode) ? 16'hFEFC : 16'hFFFC))
		else $error("wrong break vector");
	take_state_a: assert property ($rose(breakInProgress) |->
		breakpointRequest ##1 !breakpointRequest)
		else $error("break state without take pulse");
	timer_halt_a: assert property (timerHalt == breakInProgress)
		else $error("timer halt wrong");
	rti_end_a: assert property (breakInProgress &&
		returnFromInterrupt |=> !breakInProgress)
		else $error("break not ended");
	wdog_off_a: assert property (watchdogDisable ==
		(breakInProgress && $past(testHighVoltage, 2)))
		else $error("watchdog disable wrong");
	flag_gate_a: assert property (!breakInProgress |-> flagClearAllowed)
		else $error("flag clear blocked outside break");
	no_retake_a: assert property (breakInProgress &&
		$past(breakInProgress) |-> !breakpointRequest)
		else $error("take inside break");
	cover property (breakpointRequest && monitorMode);
	cover property (breakInProgress && returnFromInterrupt);
	cover property (watchdogDisable);
endmodule : abu_checker
bind address_breakpoint_unit abu_checker chk
(
	.ref_clk             (ref_clk),
	.reset               (reset),
	.monitorMode         (monitorMode),
	.testHighVoltage     (testHighVoltage),
	.returnFromInterrupt (returnFromInterrupt),
	.breakpointRequest   (breakpointRequest),
	.swiForce            (swiForce),
	.breakVector         (breakVector),
	.breakInProgress     (breakInProgress),
	.timerHalt           (timerHalt),
	.watchdogDisable     (watchdogDisable),
	.flagClearAllowed    (flagClearAllowed)
);
`default_nettype wire

// ---- core_model.sv ----
/* Core model: two-byte instructions and a timed break routine.
 Assumes the unit gives a one-cycle take pulse. */
`timescale 1ns/10ps
`default_nettype none
module core_model
(
	input wire logic	ref_clk,	// clock
	input wire logic	reset,	// reset
	input wire logic	run,	// execute
	input wire logic [15:0]	startPc,	// first opcode
	input wire logic [3:0]	rtiWait,	// routine length
	input wire logic	breakpointRequest,	// take
	output logic [15:0]	cpuAddr,	// address bus
	output logic	cpuAddrValid,	// cpu address
	output logic	opcodeFetch,	// opcode cycle
	output logic	instrBoundary,	// next instr
	output logic	returnFromInterrupt	// rti
);
	logic [15:0]	pc;
	logic	phase;
	logic	inBreak;
	logic [3:0]	cnt;
	assign cpuAddrValid = run && !inBreak;
	assign opcodeFetch = cpuAddrValid && !phase;
	assign instrBoundary = opcodeFetch;
	// idle bus shows the inverse so a stale value never matches
	assign cpuAddr = cpuAddrValid ? pc + {15'h0000, phase} : ~pc;
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			pc <= 16'h0000;
			phase <= 1'b0;
			inBreak <= 1'b0;
			cnt <= 4'h0;
			returnFromInterrupt <= 1'b0;
		end
		else if (!run)
		begin
			pc <= startPc;
			phase <= 1'b0;
		end
		else if (breakpointRequest)
		begin
			inBreak <= 1'b1;
			cnt <= rtiWait;
			phase <= 1'b0;
		end
		else if (inBreak)
		begin
			cnt <= cnt - 4'h1;
			inBreak <= cnt != 4'h0;
			returnFromInterrupt <= cnt == 4'h0;
		end
		else
		begin
			returnFromInterrupt <= 1'b0;
			phase <= !phase;
			pc <= phase ? pc + 16'h0002 : pc;
		end
	end
endmodule : core_model
`default_nettype wire

// ---- testbench.sv ----
/* Bench: break unit, core model and bus scenarios.
 Assumes unit, package, checker and model compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic	ref_clk = 1'b0;
	logic	reset = 1'b1;
	logic	wb_cyc_i = 1'b0;
	logic	wb_stb_i = 1'b0;
	logic	wb_we_i = 1'b0;
	logic	lowPowerMode = 1'b0;
	logic	monitorMode = 1'b0;
	logic	testHighVoltage = 1'b0;
	logic	run = 1'b0;
	logic [7:0]	wb_adr_i = 8'h00;
	logic [3:0]	wb_sel_i = 4'hF;
	logic [31:0]	wb_dat_i = 32'h0000_0000;
	logic [15:0]	startPc = 16'h0000;
	logic [3:0]	rtiWait = 4'hF;
	logic [31:0]	wb_dat_o, got;
	logic [15:0]	cpuAddr, breakVector;
	logic	wb_ack_o, cpuAddrValid, opcodeFetch, instrBoundary, s;
	logic	returnFromInterrupt, breakpointRequest, swiForce, irq;
	logic	breakInProgress, timerHalt, watchdogDisable, flagClearAllowed;
	int	n_mismatch = 0;
	int	total_checks = 0;
	int	cycles = 0;
	address_breakpoint_unit DUT
	(
		.ref_clk             (ref_clk),
		.reset               (reset),
		.wb_cyc_i            (wb_cyc_i),
		.wb_stb_i            (wb_stb_i),
		.wb_we_i             (wb_we_i),
		.wb_adr_i            (wb_adr_i),
		.wb_sel_i            (wb_sel_i),
		.wb_dat_i            (wb_dat_i),
		.wb_dat_o            (wb_dat_o),
		.wb_ack_o            (wb_ack_o),
		.cpuAddr             (cpuAddr),
		.cpuAddrValid        (cpuAddrValid),
		.opcodeFetch         (opcodeFetch),
		.instrBoundary       (instrBoundary),
		.returnFromInterrupt (returnFromInterrupt),
		.lowPowerMode        (lowPowerMode),
		.monitorMode         (monitorMode),
		.testHighVoltage     (testHighVoltage),
		.breakpointRequest   (breakpointRequest),
		.swiForce            (swiForce),
		.breakVector         (breakVector),
		.breakInProgress     (breakInProgress),
		.timerHalt           (timerHalt),
		.watchdogDisable     (watchdogDisable),
		.flagClearAllowed    (flagClearAllowed),
		.irq                 (irq)
	);
	core_model core
	(
		.ref_clk             (ref_clk),
		.reset               (reset),
		.run                 (run),
		.startPc             (startPc),
		.rtiWait             (rtiWait),
		.breakpointRequest   (breakpointRequest),
		.cpuAddr             (cpuAddr),
		.cpuAddrValid        (cpuAddrValid),
		.opcodeFetch         (opcodeFetch),
		.instrBoundary       (instrBoundary),
		.returnFromInterrupt (returnFromInterrupt)
	);
	always #25 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
			@(posedge ref_clk);
		while (wb_ack_o !== 1'b1);
		got = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(got, e);
	endtask : rd
	task automatic see(input int n);
		s = 1'b0;
		repeat (n)
			if (!s)
			begin
				@(posedge ref_clk);
				s = breakpointRequest === 1'b1;
			end
	endtask : see
	task automatic idle;
		while (breakInProgress !== 1'b0)
			@(posedge ref_clk);
	endtask : idle
	task automatic irqIs(input logic e);
		@(posedge ref_clk);
		chk(irq, e);
	endtask : irqIs
	task automatic arm(input logic [15:0] a, input logic [7:0] c,
		input logic [15:0] p);
		run <= 1'b0;
		startPc <= p;
		bus(1'b1, 8'h04, {24'h00_0000, a[15:8]});
		bus(1'b1, 8'h08, {24'h00_0000, a[7:0]});
		bus(1'b1, 8'h00, {24'h00_0000, c});
		run <= 1'b1;
	endtask : arm
	task automatic t_reset;
		rd(8'h00, 32'h0000_0000);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		rd(8'h3C, 32'h0000_0000);
	endtask : t_reset
	task automatic t_opcode;
		bus(1'b1, 8'h10, 32'h0000_0001);
		arm(16'h1234, 8'h80, 16'h1230);
		see(40);
		chk(s, 1'b1);
		chk(cpuAddr, 16'h1235);
		chk(breakVector, 16'hFFFC);
		chk(timerHalt, 1'b1);
		rd(8'h00, 32'h0000_00C0);
		irqIs(1'b1);
		bus(1'b1, 8'h10, 32'h0000_0000);
		irqIs(1'b0);
		bus(1'b1, 8'h10, 32'h0000_0001);
		irqIs(1'b1);
		// active cleared inside the routine, before the return
		bus(1'b1, 8'h00, 32'h0000_0080);
		see(30);
		chk(s, 1'b0);
		chk(breakInProgress, 1'b0);
		rd(8'h00, 32'h0000_0080);
		rd(8'h0C, 32'h0000_0005);
		bus(1'b1, 8'h0C, 32'h0000_0007);
		irqIs(1'b0);
	endtask : t_opcode
	task automatic t_operand;
		monitorMode <= 1'b1;
		arm(16'h1237, 8'h80, 16'h1234);
		see(40);
		chk(s, 1'b1);
		chk(cpuAddr, 16'h1239);
		chk(breakVector, 16'hFEFC);
		testHighVoltage <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(watchdogDisable, 1'b1);
		chk(flagClearAllowed, 1'b0);
		bus(1'b1, 8'h14, 32'h0000_0001);
		chk(flagClearAllowed, 1'b1);
		idle;
		monitorMode <= 1'b0;
		testHighVoltage <= 1'b0;
	endtask : t_operand
	task automatic t_soft;
		rtiWait <= 4'h1;
		arm(16'hFFFF, 8'hC0, 16'h2000);
		see(10);
		chk(s, 1'b1);
		chk(cpuAddr, 16'h2001);
		idle;
	endtask : t_soft
	task automatic t_none;
		for (int i = 0; i < 3; i++)
		begin
			lowPowerMode <= i == 2;
			arm(i == 1 ? 16'h1A34 : 16'h1234, i == 0 ? 8'h00 : 8'h80,
				16'h1230);
			see(30);
			chk(s, 1'b0);
			rd(8'h00, i == 0 ? 32'h0000_0000 : 32'h0000_0080);
		end
	endtask : t_none
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			summarize;
		end
	end
	initial
	begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_reset;
		t_opcode;
		t_operand;
		t_soft;
		t_none;
		summarize;
	end
endmodule : testbench
`default_nettype wire
